// ---- logic/gpio_pkg.sv ----
// Shared constants for the general purpose I/O port
package gpio_pkg;

	// Register bus geometry
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DEC_W    = 5;
	localparam int unsigned STRB_W   = DATA_W / 8;

	// Port geometry
	localparam int unsigned PIN_COUNT = 8;

	// Register byte offsets
	localparam logic [DEC_W-1:0] OFF_DIRECTION = 5'h00;
	localparam logic [DEC_W-1:0] OFF_OUTPUT    = 5'h04;
	localparam logic [DEC_W-1:0] OFF_INPUT     = 5'h08;
	localparam logic [DEC_W-1:0] OFF_CONTROL   = 5'h0c;
	localparam logic [DEC_W-1:0] OFF_IRQ_PIN   = 5'h10;
	localparam logic [DEC_W-1:0] OFF_CHG_MODE  = 5'h14;
	localparam logic [DEC_W-1:0] OFF_STATUS    = 5'h18;
	localparam logic [DEC_W-1:0] OFF_MASK      = 5'h1c;

	// Field positions
	localparam int unsigned CTRL_PULLUP_DIS_BIT = 0;

	// Reset values
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- logic/gpio_input_sync.sv ----
// Input clamp and latch-plus-flop synchroniser for every pin
`timescale 1ns/1ps

module gpio_input_sync #(
	parameter int unsigned WIDTH = gpio_pkg::PIN_COUNT
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	// Pin side
	input  wire logic [WIDTH-1:0] i_pin_level,
	input  wire logic [WIDTH-1:0] i_clamp,
	// Synchronised sample
	output logic      [WIDTH-1:0] o_sample
);

	logic [WIDTH-1:0] clamped_level;
	logic [WIDTH-1:0] sync_latch;

	// Clamp ahead of the buffer so a floating pin cannot toggle
	assign clamped_level = i_pin_level & ~i_clamp;

	// Open while the clock is high, closed while low
	always_latch begin
		if (i_core_clk) begin
			sync_latch <= clamped_level;
		end
	end

	// Second stage reads the latch and nothing else looks at it
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sample <= '0;
		end else begin
			o_sample <= sync_latch;
		end
	end

endmodule

// ---- logic/gpio_port.sv ----
// General purpose I/O port with register slave, pull-up decode and change interrupts
//
// Functional notes
// - Direction bit one drives, zero listens
// - Pull-up only for input, value one, enabled
// - Value zero or output turns pull-up off
// - Reset tri-states pins without a clock
// - Output drives the output value bit
// - Global pull-up disable overrides every pin
// - Input sample readable in either direction
// - Latch open on high clock, then flop
// - Pin change seen after half to 1.5 periods
// - Deep sleep clamps inputs to ground
// - Enabled interrupt pins escape the clamp
// - Clamp release on high pin sets flag
// - Pull-ups off while reset is active
// - Input sample read-only, status write-one-to-clear, others read/write
`timescale 1ns/1ps

module gpio_port #(
	parameter int unsigned WIDTH = gpio_pkg::PIN_COUNT
) (
	// Clock and reset
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst_b,
	// Write address channel
	input  wire logic [gpio_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input  wire logic                        i_s_axi_awvalid,
	output logic                             o_s_axi_awready,
	// Write data channel
	input  wire logic [gpio_pkg::DATA_W-1:0] i_s_axi_wdata,
	input  wire logic [gpio_pkg::STRB_W-1:0] i_s_axi_wstrb,
	input  wire logic                        i_s_axi_wvalid,
	output logic                             o_s_axi_wready,
	// Write response channel
	output logic [1:0]                       o_s_axi_bresp,
	output logic                             o_s_axi_bvalid,
	input  wire logic                        i_s_axi_bready,
	// Read address channel
	input  wire logic [gpio_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input  wire logic                        i_s_axi_arvalid,
	output logic                             o_s_axi_arready,
	// Read data channel
	output logic [gpio_pkg::DATA_W-1:0]      o_s_axi_rdata,
	output logic [1:0]                       o_s_axi_rresp,
	output logic                             o_s_axi_rvalid,
	input  wire logic                        i_s_axi_rready,
	// Pins
	input  wire logic [WIDTH-1:0]            i_pin_level,
	output logic      [WIDTH-1:0]            o_pin_drive,
	output logic      [WIDTH-1:0]            o_pin_drive_en,
	output logic      [WIDTH-1:0]            o_pullup_en,
	// Sleep controller
	input  wire logic                        i_deep_sleep,
	// Interrupt
	output logic                             o_irq
);

	logic [WIDTH-1:0]            direction_reg;
	logic [WIDTH-1:0]            output_value_reg;
	logic                        global_pullup_disable_reg;
	logic [WIDTH-1:0]            irq_pin_en_reg;
	logic [WIDTH-1:0]            chg_mode_reg;
	logic [WIDTH-1:0]            status_reg;
	logic [WIDTH-1:0]            mask_reg;
	logic [WIDTH-1:0]            input_sample;
	logic [WIDTH-1:0]            prev_sample_reg;
	logic [WIDTH-1:0]            change_event;
	logic [WIDTH-1:0]            sleep_clamp;
	logic                        bvalid_reg;
	logic [1:0]                  bresp_reg;
	logic                        rvalid_reg;
	logic [1:0]                  rresp_reg;
	logic [gpio_pkg::DATA_W-1:0] rdata_reg;
	logic                        wr_take;
	logic                        rd_take;
	logic [gpio_pkg::DEC_W-1:0]  wr_off;
	logic                        wr_mapped;
	logic [WIDTH-1:0]            status_clear;

	// Byte-lane merge of a write into a register
	function automatic logic [WIDTH-1:0] merge(
		input logic [WIDTH-1:0]            old_val,
		input logic [gpio_pkg::DATA_W-1:0] wdata,
		input logic [gpio_pkg::STRB_W-1:0] strb
	);
		logic [WIDTH-1:0] res;
		res = old_val;
		for (int i = 0; i < WIDTH; i++) begin
			if (strb[i / 8]) begin
				res[i] = wdata[i];
			end
		end
		return res;
	endfunction

	// Widen a pin vector to bus width, upper bits zero
	function automatic logic [gpio_pkg::DATA_W-1:0] widen(input logic [WIDTH-1:0] v);
		logic [gpio_pkg::DATA_W-1:0] res;
		res = gpio_pkg::REG_RESET;
		res[WIDTH-1:0] = v;
		return res;
	endfunction

	// Address lies inside the register window
	function automatic logic in_window(input logic [gpio_pkg::ADDR_W-1:0] a);
		return a[gpio_pkg::ADDR_W-1:gpio_pkg::DEC_W] == '0;
	endfunction

	// Pin clamp during deep sleep unless the pin wakes the core
	assign sleep_clamp = {WIDTH{i_deep_sleep}} & ~irq_pin_en_reg;

	gpio_input_sync #(
		.WIDTH (WIDTH)
	) u_input_sync (
		.i_core_clk  (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_pin_level (i_pin_level),
		.i_clamp     (sleep_clamp),
		.o_sample    (input_sample)
	);

	// Pin drivers; reset gates the enable so no clock is needed to release pins
	assign o_pin_drive    = output_value_reg;
	assign o_pin_drive_en = direction_reg & {WIDTH{i_rst_b}};

	// Pull-up decode, forced off during reset
	assign o_pullup_en = ~direction_reg & output_value_reg
		& {WIDTH{~global_pullup_disable_reg}}
		& {WIDTH{i_rst_b}};

	// Write channel: address and data are taken together, one write in flight
	assign wr_take         = i_s_axi_awvalid && i_s_axi_wvalid && !bvalid_reg;
	assign o_s_axi_awready = wr_take;
	assign o_s_axi_wready  = wr_take;
	assign wr_off          = {i_s_axi_awaddr[gpio_pkg::DEC_W-1:2], 2'h0};
	assign wr_mapped       = in_window(i_s_axi_awaddr);

	// Read channel: one read in flight
	assign rd_take         = i_s_axi_arvalid && !rvalid_reg;
	assign o_s_axi_arready = !rvalid_reg;

	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp  = bresp_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rresp  = rresp_reg;
	assign o_s_axi_rdata  = rdata_reg;

	// Direction and output value, cleared by reset
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			direction_reg    <= '0;
			output_value_reg <= '0;
		end else if (wr_take && wr_mapped) begin
			if (wr_off == gpio_pkg::OFF_DIRECTION) begin
				direction_reg <= merge(direction_reg, i_s_axi_wdata, i_s_axi_wstrb);
			end
			if (wr_off == gpio_pkg::OFF_OUTPUT) begin
				output_value_reg <= merge(output_value_reg, i_s_axi_wdata, i_s_axi_wstrb);
			end
		end
	end

	// Configuration registers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			global_pullup_disable_reg <= 1'b0;
			irq_pin_en_reg            <= '0;
			chg_mode_reg              <= '0;
			mask_reg                  <= '0;
		end else if (wr_take && wr_mapped) begin
			case (wr_off)
				gpio_pkg::OFF_CONTROL: begin
					if (i_s_axi_wstrb[0]) begin
						global_pullup_disable_reg <=
							i_s_axi_wdata[gpio_pkg::CTRL_PULLUP_DIS_BIT];
					end
				end
				gpio_pkg::OFF_IRQ_PIN: begin
					irq_pin_en_reg <= merge(irq_pin_en_reg, i_s_axi_wdata, i_s_axi_wstrb);
				end
				gpio_pkg::OFF_CHG_MODE: begin
					chg_mode_reg <= merge(chg_mode_reg, i_s_axi_wdata, i_s_axi_wstrb);
				end
				gpio_pkg::OFF_MASK: begin
					mask_reg <= merge(mask_reg, i_s_axi_wdata, i_s_axi_wstrb);
				end
				default: begin
				end
			endcase
		end
	end

	// Change detection runs on the clamped sample, so a clamp release is a change
	assign change_event = (input_sample ^ prev_sample_reg) & chg_mode_reg;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_sample_reg <= '0;
		end else begin
			prev_sample_reg <= input_sample;
		end
	end

	// Write-one-to-clear, a new event in the same cycle wins
	assign status_clear = (wr_take && wr_mapped && wr_off == gpio_pkg::OFF_STATUS)
		? merge('0, i_s_axi_wdata, i_s_axi_wstrb) : '0;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~status_clear) | change_event;
		end
	end

	// Level interrupt
	assign o_irq = |(status_reg & mask_reg);

	// Write response; the input sample location refuses writes
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= gpio_pkg::RESP_OKAY;
		end else if (wr_take) begin
			bvalid_reg <= 1'b1;
			if (!wr_mapped || wr_off == gpio_pkg::OFF_INPUT) begin
				bresp_reg <= gpio_pkg::RESP_SLVERR;
			end else begin
				bresp_reg <= gpio_pkg::RESP_OKAY;
			end
		end else if (i_s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read data, registered
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= gpio_pkg::RESP_OKAY;
			rdata_reg  <= gpio_pkg::RDATA_IDLE;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= gpio_pkg::RESP_OKAY;
			rdata_reg  <= gpio_pkg::RDATA_IDLE;
			if (!in_window(i_s_axi_araddr)) begin
				rresp_reg <= gpio_pkg::RESP_SLVERR;
			end else begin
				case ({i_s_axi_araddr[gpio_pkg::DEC_W-1:2], 2'h0})
					gpio_pkg::OFF_DIRECTION: begin
						rdata_reg <= widen(direction_reg);
					end
					gpio_pkg::OFF_OUTPUT: begin
						rdata_reg <= widen(output_value_reg);
					end
					gpio_pkg::OFF_INPUT: begin
						rdata_reg <= widen(input_sample);
					end
					gpio_pkg::OFF_CONTROL: begin
						rdata_reg[gpio_pkg::CTRL_PULLUP_DIS_BIT] <= global_pullup_disable_reg;
					end
					gpio_pkg::OFF_IRQ_PIN: begin
						rdata_reg <= widen(irq_pin_en_reg);
					end
					gpio_pkg::OFF_CHG_MODE: begin
						rdata_reg <= widen(chg_mode_reg);
					end
					gpio_pkg::OFF_STATUS: begin
						rdata_reg <= widen(status_reg);
					end
					gpio_pkg::OFF_MASK: begin
						rdata_reg <= widen(mask_reg);
					end
					default: begin
						rresp_reg <= gpio_pkg::RESP_SLVERR;
					end
				endcase
			end
		end else if (i_s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	a_drive_enable: assert property (
		o_pin_drive_en == direction_reg
	) else $error("drive enable does not follow direction");

	a_pullup_decode: assert property (
		o_pullup_en == (~direction_reg & output_value_reg & {WIDTH{~global_pullup_disable_reg}})
	) else $error("pull-up decode wrong");

	a_pullup_off: assert property (
		(o_pullup_en & (direction_reg | ~output_value_reg)) == '0
	) else $error("pull-up on for output or zero value");

	a_reset_hiz: assert property (@(posedge i_core_clk) disable iff (1'b0)
		!i_rst_b |-> (o_pin_drive_en == '0 && o_pullup_en == '0)
	) else $error("pins driven or pulled during reset");

	a_drive_value: assert property (
		wr_take && wr_mapped && wr_off == gpio_pkg::OFF_OUTPUT && i_s_axi_wstrb[0]
		|=> o_pin_drive[0] == $past(i_s_axi_wdata[0])
	) else $error("drive value not taken from write");

	a_global_disable: assert property (
		global_pullup_disable_reg |-> o_pullup_en == '0
	) else $error("pull-up on while globally disabled");

	a_input_path: assert property (
		1'b1 |=> input_sample == $past(i_pin_level & ~sleep_clamp)
	) else $error("input sample not one cycle behind pin");

	a_sleep_clamp: assert property (
		i_deep_sleep |=> (input_sample & ~$past(irq_pin_en_reg)) == '0
	) else $error("clamped pin sampled high");

	a_irq_escape: assert property (
		i_deep_sleep |=> ((input_sample ^ $past(i_pin_level)) & $past(irq_pin_en_reg)) == '0
	) else $error("enabled interrupt pin was clamped");

	a_change_flag: assert property (
		change_event[0] |=> status_reg[0] ##1 (status_reg[0] || $past(status_clear[0]))
	) else $error("change event lost");

	a_input_readonly: assert property (
		wr_take && wr_off == gpio_pkg::OFF_INPUT |=> bresp_reg == gpio_pkg::RESP_SLVERR
	) else $error("write to input sample accepted");

	c_pin_output_high: cover property (direction_reg[0] && o_pin_drive[0]);
	c_pullup_active: cover property (o_pullup_en[0]);
	c_wake_flag: cover property (i_deep_sleep ##1 !i_deep_sleep ##[1:3] change_event[0]);
	c_irq_raised: cover property ($rose(o_irq));

endmodule

// ---- test/pin_env.sv ----
// External circuitry model that drives and loads the port pins
`timescale 1ns/1ps

module pin_env (
	// Clock
	input  wire logic       i_clk,
	// Device side
	input  wire logic [7:0] i_drive,
	input  wire logic [7:0] i_drive_en,
	input  wire logic [7:0] i_pullup_en,
	// Bench control
	input  wire logic [7:0] i_ext_en,
	input  wire logic [7:0] i_ext_level,
	// Resolved pins
	output logic      [7:0] o_level
);
	logic [7:0] float_reg = 8'h55;

	// Floating pins wander, so a stale level never passes for a real one
	always @(posedge i_clk) begin
		float_reg <= ~float_reg;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_drive_en[i])
				o_level[i] = i_drive[i];
			else if (i_ext_en[i])
				o_level[i] = i_ext_level[i];
			else if (i_pullup_en[i])
				o_level[i] = 1'b1;
			else
				o_level[i] = float_reg[i];
		end
	end
endmodule

// ---- test/tb.sv ----
// Self-checking testbench for the I/O port
`timescale 1ns/1ps

module tb;
	logic clk = 1'b0, rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_en = 8'h00, ext_level = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, deep_sleep = 1'b0;
	logic bready = 1'b1, rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] drive, drive_en, pullup_en, pin_level;
	int n_fail = 0, checked = 0;

	always #50 clk = ~clk;

	gpio_port gpio_port_i (.i_core_clk(clk), .i_rst_b(rst_b),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_pin_level(pin_level),
		.o_pin_drive(drive), .o_pin_drive_en(drive_en), .o_pullup_en(pullup_en),
		.i_deep_sleep(deep_sleep), .o_irq(irq));

	pin_env pin_env_i (.i_clk(clk), .i_drive(drive), .i_drive_en(drive_en),
		.i_pullup_en(pullup_en), .i_ext_en(ext_en), .i_ext_level(ext_level),
		.o_level(pin_level));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Each channel is released at the edge that takes it, the answer taken at its own edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		resp = bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rv = rdata;
		resp = rresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#500000;
		n_fail++;
		results();
	end

	initial begin
		tick(10);
		chk({drive_en, pullup_en}, 16'h0);
		tick(10);
		rst_b <= 1'b1;
		tick(1);
		// Every location but the live input sample starts at zero
		for (int i = 0; i < 8; i++)
			if (i != 2)
				rchk(8'(i * 4), 32'h0);
		$display("test reset done");
		wr(8'h08, 32'hff);
		chk(resp, gpio_pkg::RESP_SLVERR);
		rd(8'h08);
		chk(resp, gpio_pkg::RESP_OKAY);
		wr(8'h04, 32'ha5);
		rchk(8'h04, 32'ha5);
		rd(8'h24);
		chk(resp, gpio_pkg::RESP_SLVERR);
		chk(rv, 32'h0);
		$display("test access done");
		// Direction first, then value: keeps to the safe intermediate states
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, i[2] ? 32'hff : 32'h0);
			wr(8'h04, i[1] ? 32'hff : 32'h0);
			wr(8'h0c, {31'h0, i[0]});
			chk(drive_en, i[2] ? 8'hff : 8'h0);
			chk(drive, i[1] ? 8'hff : 8'h0);
			chk(pullup_en, (i == 2) ? 8'hff : 8'h0);
		end
		rchk(8'h0c, 32'h1);
		wr(8'h0c, 32'h0);
		$display("test pin modes done");
		wr(8'h00, 32'h0);
		ext_en <= 8'hff;
		ext_level <= 8'h3c;
		tick(3);
		rchk(8'h08, 32'h3c);
		ext_en <= 8'h00;
		wr(8'h00, 32'hff);
		wr(8'h04, 32'h5a);
		rchk(8'h08, 32'h5a);
		$display("test input done");
		wr(8'h00, 32'h0f);
		wr(8'h04, 32'hff);
		chk(pullup_en, 8'hf0);
		rst_b <= 1'b0;
		#1;
		chk({drive_en, pullup_en}, 16'h0);
		tick(2);
		rst_b <= 1'b1;
		tick(1);
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h0);
		$display("test mid reset done");
		ext_en <= 8'h03;
		ext_level <= 8'h03;
		wr(8'h14, 32'h1);
		wr(8'h10, 32'h2);
		wr(8'h1c, 32'h1);
		tick(3);
		wr(8'h18, 32'hff);
		chk(irq, 1'b0);
		deep_sleep <= 1'b1;
		tick(4);
		rd(8'h08);
		chk(rv & 32'h3, 32'h2);
		wr(8'h18, 32'hff);
		deep_sleep <= 1'b0;
		tick(4);
		rchk(8'h18, 32'h1);
		chk(irq, 1'b1);
		wr(8'h1c, 32'h0);
		chk(irq, 1'b0);
		wr(8'h18, 32'h1);
		rchk(8'h18, 32'h0);
		$display("test sleep done");
		results();
	end
endmodule
